// ---- urc_fifo2.sv ----
/*
  two-entry first-in first-out buffer with valid/ready on both sides.
  assumes one clock and a synchronous reset-free flush input.
*/
`timescale 1ns/10ps
`default_nettype none
module urc_fifo2
  import urc_pkg::*;
#(
  parameter int W = RX_WORD_W
)(
  input  wire logic         clock,
  input  wire logic         rstSync_n,
  input  wire logic         flush,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  logic [W-1:0] mem [2];   // storage entries
  logic         wrPtr;     // next slot written
  logic         rdPtr;     // head slot
  logic [1:0]   count;     // entries held
  logic         push;
  logic         pop;

  // honest flags from the count
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // storage write
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and count
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end
    else if (flush)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push) wrPtr <= ~wrPtr;
      if (pop) rdPtr <= ~rdPtr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : urc_fifo2
`default_nettype wire

// ---- urc_pkg.sv ----
/*
  constants shared by the serial control block: register locations, field positions, reset values and frame
  encodings. assumes a byte-wide cpu i/o bus with a small local address.
*/
`default_nettype none
package urc_pkg;
  // local i/o addresses of the register locations
  localparam logic [2:0] ADDR_DATA    = 3'h0; // serial_data_port
  localparam logic [2:0] ADDR_STAT_A  = 3'h1; // serial_status_ctrl_a
  localparam logic [2:0] ADDR_CTRL_B  = 3'h2; // serial_ctrl_b
  localparam logic [2:0] ADDR_SHARED  = 3'h3; // baud_divisor_high / serial_ctrl_c
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4; // baud_divisor_low
  // status a fields
  localparam int A_RXC = 7;
  localparam int A_TXC = 6;
  localparam int A_TX_BUFFER_EMPTY_FLAG = 5;
  localparam int A_FE = 4;
  localparam int A_DOR = 3;
  localparam int A_PE = 2;
  localparam int A_DBL = 1;
  localparam int A_MULTIPROC_FILTER = 0;
  // control b fields
  localparam int B_RX_COMPLETE_IRQ_ENABLE = 7;
  localparam int B_TX_COMPLETE_IRQ_ENABLE = 6;
  localparam int B_BUFFER_EMPTY_IRQ_ENABLE = 5;
  localparam int B_RECEIVER_ENABLE = 4;
  localparam int B_TRANSMITTER_ENABLE = 3;
  localparam int B_SZ2 = 2;
  localparam int B_RX_NINTH_BIT = 1;
  localparam int B_TX_NINTH_BIT = 0;
  // control c fields
  localparam int C_SEL = 7;
  localparam int C_MODE = 6;
  localparam int C_PAR_HI = 5;
  localparam int C_PAR_LO = 4;
  localparam int C_STOP = 3;
  localparam int C_SZ_HI = 2;
  localparam int C_SZ_LO = 1;
  // reset values
  localparam logic [7:0] RST_STAT_A = 8'h20;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [6:0] RST_CTRL_C = 7'h06;
  localparam logic [11:0] RST_BAUD = 12'h000;
  // last oversample index per bit, normal and double speed
  localparam logic [3:0] SPB_NORMAL = 4'hF;
  localparam logic [3:0] SPB_DOUBLE = 4'h7;
  // parity field codes and the nine-bit size code
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam int RX_WORD_W = 11; // {pe, fe, ninth, data}
endpackage : urc_pkg
`default_nettype wire

// ---- urc_remote.sv ----
/*
  model of the remote serial device: sends 8-bit frames, catches frames from the block.
  assumes 8 data bits, no parity, and a fixed bit length in clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module urc_remote #(
  parameter int BIT = 16
)(
  input  wire logic       clock,
  input  wire logic       txdPin,
  input  wire logic       txdOe,
  output logic            rxdPin,
  output logic [7:0]      gotByte,
  output int              gotCount
);
  // frame sender: start, data lsb first, stop, one idle bit
  task automatic send(input logic [7:0] d, input logic stopBit);
    logic [10:0] f;
    f = {1'b1, stopBit, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clock) rxdPin <= f[i];
      repeat (BIT - 1) @(posedge clock);
    end
  endtask : send
  // frame catcher, sampling mid-bit
  initial
  begin
    rxdPin = 1'b1;
    gotByte = 8'h00;
    gotCount = 0;
    forever
    begin
      @(posedge clock);
      if (txdOe === 1'b1 && txdPin === 1'b0)
      begin
        repeat (BIT / 2) @(posedge clock);
        for (int k = 0; k < 8; k++)
        begin
          repeat (BIT) @(posedge clock);
          gotByte[k] = txdPin;
        end
        repeat (BIT) @(posedge clock);
        gotCount++;
      end
    end
  end
endmodule : urc_remote
`default_nettype wire

// ---- urc_usart.sv ----
/*
  serial transceiver register control: data port, status flags, control registers, baud divider,
  a frame transmitter and receiver. assumes a single-cycle cpu i/o bus and an asynchronous rx pin.
*/
`timescale 1ns/10ps
`default_nettype none
module urc_usart
  import urc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] ioAddr,
  input  wire logic       ioWrite,
  input  wire logic       ioRead,
  input  wire logic [7:0] ioWdata,
  output logic [7:0]      ioRdata,
  input  wire logic       globalIrqEnable,
  input  wire logic       txcIrqAck,
  input  wire logic       rxdPin,
  output logic            rxdOwned,
  output logic            txdPin,
  output logic            txdOe,
  output logic            irqRxComplete,
  output logic            irqTxComplete,
  output logic            irqBufEmpty,
  output logic            syncMode
);
  typedef enum logic [2:0] {
    URC_IDLE  = 3'b000,
    URC_START = 3'b001,
    URC_DATA  = 3'b010,
    URC_PAR   = 3'b011,
    URC_STOP  = 3'b100,
    URC_STOP2 = 3'b101
  } urc_state_e;

  // character length in bits from the size code
  function automatic logic [3:0] charBits(input logic [2:0] code);
    charBits = (code == SIZE_NINE) ? 4'h9 : 4'h5 + {2'b00, code[1:0]};
  endfunction : charBits

  // parity of the valid data bits
  function automatic logic parityOf(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
      if (4'(i) < n) p = p ^ d[i];
    parityOf = p;
  endfunction : parityOf

  logic [1:0]  rstPipe;           // reset release stages
  logic        rstSync_n;         // released reset
  logic [7:0]  statA;             // writable bits of status a
  logic        txComplete;        // tx complete flag
  logic        overrun;           // overrun flag
  logic [7:0]  ctrlB;             // control b (rx ninth bit read live)
  logic [6:0]  ctrlC;             // control c without select bit
  logic [11:0] baudDiv;           // baud divisor
  logic [11:0] baudCnt;           // prescaler count
  logic        smpTick;           // oversample tick
  logic        prevSharedRd;      // shared read in previous cycle
  logic [2:0]  sizeCode;          // combined character size
  logic [3:0]  nBits;             // data bits per character
  logic [3:0]  spbLast;           // last oversample index
  logic        parOn;             // parity enabled
  logic        wrData;            // cpu write of data port
  logic        rdData;            // cpu read of data port
  logic [8:0]  txHold;            // tx holding buffer
  logic        txHoldFull;        // holding buffer occupied
  urc_state_e  txState;           // transmitter state
  logic [8:0]  txShift;           // tx shift register
  logic [3:0]  txSmp;             // tx oversample count
  logic [3:0]  txIdx;             // tx bit index
  logic        txPar;             // tx parity latched
  logic        txLine;            // tx serial level
  logic        txOn;              // transmitter owns the pin
  logic        txLoad;            // holding buffer to shifter
  logic        txBitEnd;          // end of tx bit time
  logic        txFrameEnd;        // last stop bit done
  logic [2:0]  rxSync;            // pin synchroniser
  logic        rxLevel;           // debounced rx level
  urc_state_e  rxState;           // receiver state
  logic [3:0]  rxSmp;             // rx oversample count
  logic [3:0]  rxIdx;             // rx bit index
  logic [8:0]  rxShift;           // rx data collector
  logic        rxParBad;          // parity mismatch
  logic        rxSample;          // rx sample point
  logic        rxStartSeen;       // start bit detected
  logic        pendValid;         // character waiting for fifo
  logic [10:0] pendWord;          // waiting character
  logic        fifoReady;         // fifo accepts
  logic        fifoValid;         // fifo holds data
  logic [10:0] fifoHead;          // head character
  logic        rxFlush;           // receiver disabled

  // reset release through two stages
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) rstPipe <= 2'b00;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_n = rstPipe[1];

  // frame format decode
  assign sizeCode = {ctrlB[B_SZ2], ctrlC[C_SZ_HI:C_SZ_LO]};
  assign nBits = charBits(sizeCode);
  assign parOn = ctrlC[C_PAR_HI];
  assign syncMode = ctrlC[C_MODE];
  assign spbLast = (statA[A_DBL] && !syncMode) ? SPB_DOUBLE : SPB_NORMAL;
  assign wrData = ioWrite && (ioAddr == ADDR_DATA);
  assign rdData = ioRead && (ioAddr == ADDR_DATA);
  assign rxFlush = !ctrlB[B_RECEIVER_ENABLE];

  // writable register bits
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      statA <= RST_STAT_A;
      ctrlB <= RST_CTRL_B;
      ctrlC <= RST_CTRL_C;
      baudDiv <= RST_BAUD;
    end
    else if (ioWrite)
    begin
      case (ioAddr)
        ADDR_STAT_A: statA[A_DBL:A_MULTIPROC_FILTER] <= ioWdata[A_DBL:A_MULTIPROC_FILTER];
        ADDR_CTRL_B: ctrlB <= ioWdata;
        ADDR_SHARED:
          if (ioWdata[C_SEL]) ctrlC <= ioWdata[6:0];
          else baudDiv[11:8] <= ioWdata[3:0];
        ADDR_BAUD_LO: baudDiv[7:0] <= ioWdata[7:0];
        default: ;
      endcase
    end
  end

  // prescaler, restarted by a low-byte write
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n) baudCnt <= RST_BAUD;
    else if (ioWrite && ioAddr == ADDR_BAUD_LO) baudCnt <= {baudDiv[11:8], ioWdata};
    else if (baudCnt == 12'h000) baudCnt <= baudDiv;
    else baudCnt <= baudCnt - 12'h001;
  end
  assign smpTick = (baudCnt == 12'h000);

  // shared location read timing
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n) prevSharedRd <= 1'b0;
    else prevSharedRd <= ioRead && (ioAddr == ADDR_SHARED);
  end

  // read data capture
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n) ioRdata <= 8'h00;
    else if (ioRead)
    begin
      case (ioAddr)
        ADDR_DATA: ioRdata <= fifoValid ? fifoHead[7:0] : 8'h00;
        ADDR_STAT_A: ioRdata <= {fifoValid, txComplete, !txHoldFull,
                                 fifoValid & fifoHead[9], overrun,
                                 fifoValid & fifoHead[10], statA[A_DBL:A_MULTIPROC_FILTER]};
        ADDR_CTRL_B: ioRdata <= {ctrlB[7:2], fifoHead[8] & fifoValid, ctrlB[B_TX_NINTH_BIT]};
        ADDR_SHARED:
          if (prevSharedRd) ioRdata <= {1'b1, ctrlC};
          else ioRdata <= {4'h0, baudDiv[11:8]};
        ADDR_BAUD_LO: ioRdata <= baudDiv[7:0];
        default: ioRdata <= 8'h00;
      endcase
    end
  end

  // transmit holding buffer
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      txHold <= 9'h000;
      txHoldFull <= 1'b0;
    end
    else if (wrData && !txHoldFull)
    begin
      txHold <= {ctrlB[B_TX_NINTH_BIT], ioWdata};
      txHoldFull <= 1'b1;
    end
    else if (txLoad) txHoldFull <= 1'b0;
  end

  // transmitter ownership of the pin
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n) txOn <= 1'b0;
    else if (ctrlB[B_TRANSMITTER_ENABLE]) txOn <= 1'b1;
    else if (txState == URC_IDLE && !txHoldFull) txOn <= 1'b0;
  end

  assign txLoad = txOn && txHoldFull && txState == URC_IDLE;
  assign txBitEnd = smpTick && txSmp == spbLast;
  assign txFrameEnd = txBitEnd && (txState == URC_STOP2 || (txState == URC_STOP && !ctrlC[C_STOP]));

  // transmit frame sequencer
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      txState <= URC_IDLE;
      txShift <= 9'h000;
      txSmp <= 4'h0;
      txIdx <= 4'h0;
      txPar <= 1'b0;
      txLine <= 1'b1;
    end
    else
    begin
      if (smpTick) txSmp <= (txSmp == spbLast) ? 4'h0 : txSmp + 4'h1;
      case (txState)
        URC_IDLE:
        begin
          txLine <= 1'b1;
          if (txLoad)
          begin
            txShift <= txHold;
            txPar <= parityOf(txHold, nBits, ctrlC[C_PAR_LO]);
            txState <= URC_START;
            txSmp <= 4'h0;
            txLine <= 1'b0;
          end
        end
        URC_START:
          if (txBitEnd)
          begin
            txState <= URC_DATA;
            txIdx <= 4'h0;
            txLine <= txShift[0];
          end
        URC_DATA:
          if (txBitEnd)
          begin
            if (txIdx == nBits - 4'h1)
            begin
              txState <= parOn ? URC_PAR : URC_STOP;
              txLine <= parOn ? txPar : 1'b1;
            end
            else
            begin
              txIdx <= txIdx + 4'h1;
              txLine <= txShift[txIdx + 4'h1];
            end
          end
        URC_PAR:
          if (txBitEnd)
          begin
            txState <= URC_STOP;
            txLine <= 1'b1;
          end
        URC_STOP:
          if (txBitEnd) txState <= ctrlC[C_STOP] ? URC_STOP2 : URC_IDLE;
        URC_STOP2:
          if (txBitEnd) txState <= URC_IDLE;
        default: txState <= URC_IDLE;
      endcase
    end
  end

  // transmit complete flag, set beats clear
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n) txComplete <= 1'b0;
    else if (txFrameEnd && !txHoldFull) txComplete <= 1'b1;
    else if (txcIrqAck || (ioWrite && ioAddr == ADDR_STAT_A && ioWdata[A_TXC])) txComplete <= 1'b0;
  end

  assign txdPin = txOn ? txLine : 1'b1;
  assign txdOe = txOn;

  // rx pin synchroniser
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rxSync <= 3'b111;
      rxLevel <= 1'b1;
    end
    else
    begin
      rxSync <= {rxSync[1:0], rxdPin};
      if (rxSync[2] == rxSync[1]) rxLevel <= rxSync[1];
    end
  end

  assign rxdOwned = ctrlB[B_RECEIVER_ENABLE];
  assign rxStartSeen = rxState == URC_IDLE && ctrlB[B_RECEIVER_ENABLE] && !rxLevel;
  assign rxSample = smpTick && rxSmp == {1'b0, spbLast[3:1]};

  // receive frame sequencer, samples at mid bit
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rxState <= URC_IDLE;
      rxSmp <= 4'h0;
      rxIdx <= 4'h0;
      rxShift <= 9'h000;
      rxParBad <= 1'b0;
    end
    else if (rxFlush) rxState <= URC_IDLE;
    else
    begin
      if (smpTick) rxSmp <= (rxSmp == spbLast) ? 4'h0 : rxSmp + 4'h1;
      case (rxState)
        URC_IDLE:
          if (rxStartSeen)
          begin
            rxState <= URC_START;
            rxSmp <= 4'h0;
          end
        URC_START:
          if (rxSample)
          begin
            rxState <= rxLevel ? URC_IDLE : URC_DATA;
            rxIdx <= 4'h0;
            rxShift <= 9'h000;
          end
        URC_DATA:
          if (rxSample)
          begin
            rxShift[rxIdx] <= rxLevel;
            rxIdx <= rxIdx + 4'h1;
            if (rxIdx == nBits - 4'h1) rxState <= parOn ? URC_PAR : URC_STOP;
          end
        URC_PAR:
          if (rxSample)
          begin
            rxParBad <= parityOf(rxShift, nBits, ctrlC[C_PAR_LO]) != rxLevel;
            rxState <= URC_STOP;
          end
        URC_STOP:
          if (rxSample) rxState <= URC_IDLE;
        default: rxState <= URC_IDLE;
      endcase
    end
  end

  // character handed to the fifo, held while full
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      pendValid <= 1'b0;
      pendWord <= 11'h000;
    end
    else if (rxFlush) pendValid <= 1'b0;
    else if (rxState == URC_STOP && rxSample)
    begin
      // address indication: ninth bit or first stop bit
      if (!statA[A_MULTIPROC_FILTER] || (sizeCode == SIZE_NINE ? rxShift[8] : rxLevel))
      begin
        pendValid <= 1'b1;
        pendWord <= {parOn & rxParBad, !rxLevel, rxShift};
      end
    end
    else if (fifoReady) pendValid <= 1'b0;
  end

  // overrun flag, set beats the read clear
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n) overrun <= 1'b0;
    else if (rxFlush) overrun <= 1'b0;
    else if (pendValid && !fifoReady && rxStartSeen) overrun <= 1'b1;
    else if (rdData) overrun <= 1'b0;
  end

  // two-entry receive buffer, popped by any data port read
  urc_fifo2 #(
    .W (RX_WORD_W)
  ) rxFifo (
    .clock     (clock),
    .rstSync_n (rstSync_n),
    .flush     (rxFlush),
    .inValid   (pendValid),
    .inReady   (fifoReady),
    .inData    (pendWord),
    .outValid  (fifoValid),
    .outReady  (rdData),
    .outData   (fifoHead)
  );

  // interrupt requests
  assign irqRxComplete = ctrlB[B_RX_COMPLETE_IRQ_ENABLE] && globalIrqEnable && fifoValid;
  assign irqTxComplete = ctrlB[B_TX_COMPLETE_IRQ_ENABLE] && globalIrqEnable && txComplete;
  assign irqBufEmpty = ctrlB[B_BUFFER_EMPTY_IRQ_ENABLE] && globalIrqEnable && !txHoldFull;
endmodule : urc_usart
`default_nettype wire

// ---- urc_usart_bench.sv ----
/*
  self-checking bench for the serial control block with a remote device model.
  assumes divisor 0, so one bit lasts 16 clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module urc_usart_bench
  import urc_pkg::*;
;
  logic       clock, rst_n, ioWrite, ioRead, globalIrqEnable, txcIrqAck;
  logic [2:0] ioAddr;
  logic [7:0] ioWdata, ioRdata;
  logic       rxdPin, rxdOwned, txdPin, txdOe, irqRx, irqTx, irqBuf, syncMode;
  logic [7:0] gotByte;
  int         gotCount, fails, nTests;
  urc_usart i_dut (.clock(clock), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .globalIrqEnable(globalIrqEnable), .txcIrqAck(txcIrqAck),
    .rxdPin(rxdPin), .rxdOwned(rxdOwned), .txdPin(txdPin), .txdOe(txdOe), .irqRxComplete(irqRx),
    .irqTxComplete(irqTx), .irqBufEmpty(irqBuf), .syncMode(syncMode));
  urc_remote #(.BIT(16)) i_remote (.clock(clock), .txdPin(txdPin), .txdOe(txdOe), .rxdPin(rxdPin),
    .gotByte(gotByte), .gotCount(gotCount));
  // verdict and end of run
  task automatic end_sim;
    if (fails == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    ioAddr <= a;
    ioWdata <= d;
    ioWrite <= 1'b1;
    @(posedge clock);
    ioWrite <= 1'b0;
  endtask : wr
  // read, then compare
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string w);
    @(posedge clock);
    ioAddr <= a;
    ioRead <= 1'b1;
    @(posedge clock);
    ioRead <= 1'b0;
    #1 chk(w, ioRdata, e);
  endtask : rc
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    end_sim();
  end
  initial
  begin
    {rst_n, ioWrite, ioRead, globalIrqEnable, txcIrqAck, ioAddr, ioWdata} = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rc(ADDR_STAT_A, 8'h20, "status reset");
    chk("tx pin idle", {6'h00, txdOe, txdPin}, 8'h01);
    // shared location
    wr(ADDR_SHARED, 8'h0A);
    wr(ADDR_SHARED, 8'hC6);
    #1 chk("sync mode", {7'h00, syncMode}, 8'h01);
    wr(ADDR_SHARED, 8'h86);
    #1 chk("async mode", {7'h00, syncMode}, 8'h00);
    @(posedge clock);
    ioAddr <= ADDR_SHARED;
    ioRead <= 1'b1;
    @(posedge clock);
    #1 chk("shared first", ioRdata, 8'h0A);
    @(posedge clock);
    ioRead <= 1'b0;
    #1 chk("shared second", ioRdata, 8'h86);
    wr(ADDR_SHARED, 8'h00);
    rc(ADDR_SHARED, 8'h00, "shared lone");
    // low byte write restarts the prescaler left counting from the high byte
    wr(ADDR_BAUD_LO, 8'h00);
    rc(ADDR_BAUD_LO, 8'h00, "baud low");
    // status a writable bits only
    wr(ADDR_STAT_A, 8'hE3);
    rc(ADDR_STAT_A, 8'h23, "status write");
    wr(ADDR_STAT_A, 8'h00);
    // transmit, full buffer drop, late disable
    globalIrqEnable <= 1'b1;
    wr(ADDR_CTRL_B, 8'h28);
    #1 chk("empty irq", {7'h00, irqBuf}, 8'h01);
    wr(ADDR_DATA, 8'hA5);
    repeat (2) @(posedge clock);
    wr(ADDR_DATA, 8'h3C);
    wr(ADDR_DATA, 8'h77);
    rc(ADDR_STAT_A, 8'h00, "buffer full");
    wr(ADDR_CTRL_B, 8'h40);
    #1 chk("tx still owns", {7'h00, txdOe}, 8'h01);
    for (int i = 0; i < 1000 && gotCount < 1; i++) @(posedge clock);
    chk("first frame", gotByte, 8'hA5);
    for (int i = 0; i < 1000 && gotCount < 2; i++) @(posedge clock);
    chk("second frame", gotByte, 8'h3C);
    repeat (40) @(posedge clock);
    rc(ADDR_STAT_A, 8'h60, "tx complete");
    chk("tx irq", {6'h00, irqTx, txdOe}, 8'h02);
    globalIrqEnable <= 1'b0;
    @(posedge clock);
    #1 chk("tx irq masked", {7'h00, irqTx}, 8'h00);
    globalIrqEnable <= 1'b1;
    txcIrqAck <= 1'b1;
    @(posedge clock);
    txcIrqAck <= 1'b0;
    rc(ADDR_STAT_A, 8'h20, "tx complete ack");
    repeat (200) @(posedge clock);
    chk("dropped word", 8'(gotCount), 8'h02);
    // receive, frame error, empty read
    wr(ADDR_CTRL_B, 8'h90);
    #1 chk("rx owns pin", {7'h00, rxdOwned}, 8'h01);
    i_remote.send(8'h11, 1'b1);
    i_remote.send(8'h22, 1'b0);
    rc(ADDR_STAT_A, 8'hA0, "rx head good");
    chk("rx irq", {7'h00, irqRx}, 8'h01);
    rc(ADDR_CTRL_B, 8'h90, "rx ninth bit");
    rc(ADDR_DATA, 8'h11, "rx first");
    rc(ADDR_STAT_A, 8'hB0, "frame error");
    rc(ADDR_DATA, 8'h22, "rx second");
    rc(ADDR_STAT_A, 8'h20, "rx empty");
    rc(ADDR_DATA, 8'h00, "empty read");
    // overrun, then flush by disable
    for (int i = 1; i < 5; i++) i_remote.send(8'(i), 1'b1);
    rc(ADDR_STAT_A, 8'hA8, "overrun");
    wr(ADDR_CTRL_B, 8'h00);
    rc(ADDR_STAT_A, 8'h20, "rx flushed");
    // multiprocessor filter
    wr(ADDR_STAT_A, 8'h01);
    wr(ADDR_CTRL_B, 8'h10);
    i_remote.send(8'h55, 1'b0);
    rc(ADDR_STAT_A, 8'h21, "data frame dropped");
    i_remote.send(8'h66, 1'b1);
    rc(ADDR_DATA, 8'h66, "address frame kept");
    // even parity: the remote's stop slot becomes the parity bit
    wr(ADDR_STAT_A, 8'h00);
    wr(ADDR_SHARED, 8'hA6);
    i_remote.send(8'h03, 1'b1);
    rc(ADDR_STAT_A, 8'hA4, "parity error");
    rc(ADDR_DATA, 8'h03, "parity data");
    i_remote.send(8'h03, 1'b0);
    rc(ADDR_STAT_A, 8'hA0, "parity good");
    end_sim();
  end
endmodule : urc_usart_bench
`default_nettype wire

// ---- urc_usart_chk.sv ----
/*
  assertion checker for the serial control block, bound to its top module.
  assumes the port timing and register locations of the block's package.
*/
`timescale 1ns/10ps
`default_nettype none
module urc_usart_chk
  import urc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [2:0] ioAddr,
  input wire logic       ioWrite,
  input wire logic       ioRead,
  input wire logic [7:0] ioWdata,
  input wire logic [7:0] ioRdata,
  input wire logic       globalIrqEnable,
  input wire logic       rxdOwned,
  input wire logic       txdPin,
  input wire logic       txdOe,
  input wire logic       irqRxComplete,
  input wire logic       irqTxComplete,
  input wire logic       irqBufEmpty,
  input wire logic       syncMode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic shRd; // shared location read
  logic shWr; // shared location write
  logic bWr;  // control b write
  assign shRd = ioRead && (ioAddr == ADDR_SHARED);
  assign shWr = ioWrite && (ioAddr == ADDR_SHARED);
  assign bWr  = ioWrite && (ioAddr == ADDR_CTRL_B);
  // requests need the global flag
  irq_rx_gate_a: assert property (irqRxComplete |-> globalIrqEnable)
    else $error("rx irq without global flag");
  irq_tx_gate_a: assert property (irqTxComplete |-> globalIrqEnable)
    else $error("tx irq without global flag");
  irq_empty_gate_a: assert property (irqBufEmpty |-> globalIrqEnable)
    else $error("empty irq without global flag");
  // shared location read sequence
  shared_pair_a: assert property (shRd ##1 shRd |=> ioRdata[7])
    else $error("second shared read lacks select bit");
  shared_lone_a: assert property (!shRd ##1 shRd |=> ioRdata[7:4] == 4'h0)
    else $error("lone shared read not baud high");
  // shared location writes steered by select
  mode_write_a: assert property (shWr && ioWdata[C_SEL] |=> syncMode == $past(ioWdata[C_MODE]))
    else $error("mode bit not taken");
  mode_keep_a: assert property (shWr && !ioWdata[C_SEL] |=> $stable(syncMode))
    else $error("baud write changed mode");
  // receiver pin ownership
  rx_owner_a: assert property (bWr |=> rxdOwned == $past(ioWdata[B_RECEIVER_ENABLE]))
    else $error("rx ownership not following enable");
  // released line idles high
  line_idle_a: assert property (!txdOe |-> txdPin)
    else $error("released tx line not high");
  pair_seen_c: cover property (shRd ##1 shRd);
  rx_irq_c: cover property (irqRxComplete);
  tx_irq_c: cover property (irqTxComplete);
endmodule : urc_usart_chk
bind urc_usart urc_usart_chk i_chk (.clock(clock), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrite(ioWrite),
  .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .globalIrqEnable(globalIrqEnable),
  .rxdOwned(rxdOwned), .txdPin(txdPin), .txdOe(txdOe), .irqRxComplete(irqRxComplete),
  .irqTxComplete(irqTxComplete), .irqBufEmpty(irqBufEmpty), .syncMode(syncMode));
`default_nettype wire
